// file: dppsc_pkg.sv
// package of constants and types for the dual-port power-state controller
// Contract
// [RQ1] port enable is pin OR shadow bit
// [RQ2] trip mode opens switch at current limit
// [RQ3] constant-current keeps switch closed until undervoltage
// [RQ4] stand-alone uses only enable pins and alerts
// [RQ5] below supply threshold: off, state lost, open
// [RQ6] sleep keeps state, wakes for bus access
// [RQ7] any channel fault means error, recorded per channel; faults on an idle channel with its enable off are ignored
// [RQ8] fault affects only its own channel
// [RQ9] active when sourcing without fault, second priority
// [RQ10] sleep only when both enables inactive
// [RQ11] after recovery period, recheck, return if clear
// [RQ12] fault beats enable in the same cycle
package dppsc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_PORT_CONFIG_A = 8'h11;
  localparam logic [7:0] ADDR_PORT_CONFIG_B = 8'h12;
  localparam logic [7:0] ADDR_STATUS_1 = 8'h02;
  localparam logic [7:0] ADDR_STATUS_2 = 8'h03;
  localparam logic [7:0] ADDR_POWER_STATE = 8'h04;
  localparam logic [7:0] RESET_CONFIG = 8'h00;
  // configuration bit positions
  localparam int BIT_SHADOW_EN = 0;
  localparam int BIT_CC_MODE = 1;
  localparam int BIT_AUTO_RECOVER = 2;
  // status bit positions
  localparam int BIT_ST_OVERCURRENT = 0;
  localparam int BIT_ST_UNDERVOLT = 1;
  localparam int BIT_ST_OTHER = 2;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_CYCLE_US = 20;
  localparam int T_CYCLE_CNT = (T_CYCLE_US * 1000) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  // power states
  typedef enum logic [1:0] {PS_SLEEP, PS_ACTIVE, PS_ERROR} dppsc_state_e;
  // per-channel states
  typedef enum logic [1:0] {CH_IDLE, CH_ON, CH_FAULT} dppsc_ch_e;
endpackage

// file: dppsc_regs.sv
// register store for the two port configuration bytes
`timescale 1ns/1ps
module dppsc_regs
  import dppsc_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic wr_i, // write strobe
  input wire logic [7:0] addr_i, // register address
  input wire logic [7:0] wdata_i, // write data
  output logic [7:0] cfg_a_o, // port 1 configuration
  output logic [7:0] cfg_b_o // port 2 configuration
);
  // registers are retained in sleep; reset models power loss
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_a_o <= RESET_CONFIG; // RQ5
      cfg_b_o <= RESET_CONFIG;
    end else if (wr_i) begin
      if (addr_i == ADDR_PORT_CONFIG_A) cfg_a_o <= wdata_i;
      if (addr_i == ADDR_PORT_CONFIG_B) cfg_b_o <= wdata_i;
    end
  end
endmodule

// file: dppsc_channel.sv
// one port channel: switch control, limiting and fault recovery
`timescale 1ns/1ps
module dppsc_channel
  import dppsc_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic enable_i, // effective enable control
  input wire logic cc_mode_i, // constant-current limiting
  input wire logic auto_recover_i, // automatic recovery
  input wire logic at_limit_i, // current reached limit
  input wire logic vbus_low_i, // port voltage below minimum
  input wire logic other_fault_i, // other fault sources
  output logic switch_on_o, // switch closed
  output logic fault_o, // in fault handling
  output logic [2:0] status_o // sticky fault record
);
  dppsc_ch_e st_q;
  logic [CNT_W-1:0] cnt_q;
  logic trip;
  logic fault_now;
  logic take_fault;

  // trip mode opens at limit; cc mode only on voltage sag
  assign trip = cc_mode_i ? vbus_low_i : at_limit_i; // RQ2 RQ3
  assign fault_now = trip || other_fault_i;
  // a fault seen with an enable request wins over turning on
  assign take_fault = fault_now && (st_q != CH_FAULT) && (st_q == CH_ON || enable_i); // RQ12

  // channel state; fault checked before enable
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= CH_IDLE;
      cnt_q <= '0;
    end else begin
      unique case (st_q)
        CH_IDLE, CH_ON: begin
          if (take_fault) begin
            st_q <= CH_FAULT; // RQ12 RQ8
            cnt_q <= '0;
          end else if (enable_i) begin
            st_q <= CH_ON;
          end else begin
            st_q <= CH_IDLE;
          end
        end
        CH_FAULT: begin
          if (cnt_q == CNT_W'(T_CYCLE_CNT - 1)) begin
            cnt_q <= '0;
            // recheck every condition only after the period
            if (auto_recover_i && !fault_now) begin
              st_q <= enable_i ? CH_ON : CH_IDLE; // RQ11
            end
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        // the fourth code is never entered; fall back to idle if it is
        default: begin
          st_q <= CH_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  assign switch_on_o = (st_q == CH_ON);
  assign fault_o = (st_q == CH_FAULT);

  // sticky record of detected faults; kept until reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_o <= '0;
    end else if (take_fault) begin
      status_o[BIT_ST_OVERCURRENT] <= status_o[BIT_ST_OVERCURRENT] | (at_limit_i & ~cc_mode_i);
      status_o[BIT_ST_UNDERVOLT] <= status_o[BIT_ST_UNDERVOLT] | (vbus_low_i & cc_mode_i);
      status_o[BIT_ST_OTHER] <= status_o[BIT_ST_OTHER] | other_fault_i; // RQ7
    end
  end
endmodule

// file: dppsc_top.sv
// top of the dual-port power-state controller
`timescale 1ns/1ps
module dppsc_top
  import dppsc_pkg::*;
(
  input wire logic CLK_SYS_I, // 100 MHz system clock
  input wire logic RESET_N_I, // supply-good reset, active low
  input wire logic PORT1_SWITCH_REQUEST_I, // port 1 enable pin
  input wire logic PORT2_SWITCH_REQUEST_I, // port 2 enable pin
  input wire logic PORT1_AT_LIMIT_I, // port 1 current at limit
  input wire logic PORT2_AT_LIMIT_I, // port 2 current at limit
  input wire logic PORT1_VBUS_LOW_I, // port 1 voltage below minimum
  input wire logic PORT2_VBUS_LOW_I, // port 2 voltage below minimum
  input wire logic PORT1_OTHER_FAULT_I, // port 1 other faults
  input wire logic PORT2_OTHER_FAULT_I, // port 2 other faults
  input wire logic REG_WR_I, // register write strobe
  input wire logic [7:0] REG_ADDR_I, // register address
  input wire logic [7:0] REG_WDATA_I, // register write data
  output logic [7:0] REG_RDATA_O, // register read data
  output logic PORT1_SWITCH_ON_O, // port 1 switch closed
  output logic PORT2_SWITCH_ON_O, // port 2 switch closed
  output logic PORT1_FAULT_OUT_N_O, // port 1 alert, low asserted
  output logic PORT2_FAULT_OUT_N_O, // port 2 alert, low asserted
  output logic PORT1_FAULT_OUT_N_OE_O, // port 1 alert drive enable
  output logic PORT2_FAULT_OUT_N_OE_O, // port 2 alert drive enable
  output logic [1:0] POWER_STATE_O // overall power state
);
  // ****************************************
  // configuration and enable controls
  // ****************************************
  logic [7:0] cfg_a;
  logic [7:0] cfg_b;
  logic en1;
  logic en2;
  logic sw1;
  logic sw2;
  logic flt1;
  logic flt2;
  logic [2:0] st1;
  logic [2:0] st2;
  dppsc_state_e ps_d;

  dppsc_regs u_regs (
    .clk_i(CLK_SYS_I),
    .reset_n_i(RESET_N_I),
    .wr_i(REG_WR_I),
    .addr_i(REG_ADDR_I),
    .wdata_i(REG_WDATA_I),
    .cfg_a_o(cfg_a),
    .cfg_b_o(cfg_b)
  );

  // pin and shadow bit act alike; stand-alone leaves shadows at zero
  assign en1 = PORT1_SWITCH_REQUEST_I | cfg_a[BIT_SHADOW_EN]; // RQ1 RQ4
  assign en2 = PORT2_SWITCH_REQUEST_I | cfg_b[BIT_SHADOW_EN]; // RQ1

  // ****************************************
  // channels
  // ****************************************
  dppsc_channel u_ch1 (
    .clk_i(CLK_SYS_I),
    .reset_n_i(RESET_N_I),
    .enable_i(en1),
    .cc_mode_i(cfg_a[BIT_CC_MODE]),
    .auto_recover_i(cfg_a[BIT_AUTO_RECOVER]),
    .at_limit_i(PORT1_AT_LIMIT_I),
    .vbus_low_i(PORT1_VBUS_LOW_I),
    .other_fault_i(PORT1_OTHER_FAULT_I),
    .switch_on_o(sw1),
    .fault_o(flt1),
    .status_o(st1)
  );

  dppsc_channel u_ch2 (
    .clk_i(CLK_SYS_I),
    .reset_n_i(RESET_N_I),
    .enable_i(en2),
    .cc_mode_i(cfg_b[BIT_CC_MODE]),
    .auto_recover_i(cfg_b[BIT_AUTO_RECOVER]),
    .at_limit_i(PORT2_AT_LIMIT_I),
    .vbus_low_i(PORT2_VBUS_LOW_I),
    .other_fault_i(PORT2_OTHER_FAULT_I),
    .switch_on_o(sw2),
    .fault_o(flt2),
    .status_o(st2)
  );

  // ****************************************
  // overall power state
  // ****************************************
  // error first, then active, sleep only when both idle
  always_comb begin
    if (flt1 || flt2) begin
      ps_d = PS_ERROR; // RQ7
    end else if (sw1 || sw2) begin
      ps_d = PS_ACTIVE; // RQ9
    end else begin
      ps_d = PS_SLEEP; // RQ10 RQ6
    end
  end

  // outputs registered; switches open while reset stands for power loss
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      PORT1_SWITCH_ON_O <= 1'b0; // RQ5
      PORT2_SWITCH_ON_O <= 1'b0;
      PORT1_FAULT_OUT_N_O <= 1'b0;
      PORT2_FAULT_OUT_N_O <= 1'b0;
      PORT1_FAULT_OUT_N_OE_O <= 1'b0;
      PORT2_FAULT_OUT_N_OE_O <= 1'b0;
      POWER_STATE_O <= 2'h0;
    end else begin
      PORT1_SWITCH_ON_O <= sw1; // RQ8
      PORT2_SWITCH_ON_O <= sw2;
      PORT1_FAULT_OUT_N_O <= 1'b0; // open-drain data is always low
      PORT2_FAULT_OUT_N_O <= 1'b0;
      PORT1_FAULT_OUT_N_OE_O <= flt1; // open drain: drive low only on fault
      PORT2_FAULT_OUT_N_OE_O <= flt2;
      POWER_STATE_O <= ps_d;
    end
  end

  // register reads stay available in sleep
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O <= 8'h00;
    end else begin
      unique case (REG_ADDR_I)
        ADDR_PORT_CONFIG_A: REG_RDATA_O <= cfg_a; // RQ6
        ADDR_PORT_CONFIG_B: REG_RDATA_O <= cfg_b;
        ADDR_STATUS_1: REG_RDATA_O <= {5'h00, st1};
        ADDR_STATUS_2: REG_RDATA_O <= {5'h00, st2};
        ADDR_POWER_STATE: REG_RDATA_O <= {6'h00, ps_d};
        default: REG_RDATA_O <= 8'h00;
      endcase
    end
  end
endmodule

// file: dppsc_top_props.sv
// port checker for the dual-port power-state controller
`timescale 1ns/1ps
module dppsc_top_props
  import dppsc_pkg::*;
(
  input wire logic CLK_SYS_I, // clock
  input wire logic RESET_N_I, // reset, active low
  input wire logic PORT1_SWITCH_REQUEST_I, // pin 1
  input wire logic PORT2_SWITCH_REQUEST_I, // pin 2
  input wire logic PORT1_AT_LIMIT_I, // limit 1
  input wire logic PORT2_AT_LIMIT_I, // limit 2
  input wire logic PORT1_VBUS_LOW_I, // low 1
  input wire logic PORT2_VBUS_LOW_I, // low 2
  input wire logic PORT1_OTHER_FAULT_I, // other 1
  input wire logic REG_WR_I, // write strobe
  input wire logic [7:0] REG_ADDR_I, // address
  input wire logic [7:0] REG_WDATA_I, // write data
  input wire logic [7:0] REG_RDATA_O, // read data
  input wire logic PORT1_SWITCH_ON_O, // switch 1
  input wire logic PORT2_SWITCH_ON_O, // switch 2
  input wire logic PORT1_FAULT_OUT_N_OE_O, // alert 1
  input wire logic PORT2_FAULT_OUT_N_OE_O, // alert 2
  input wire logic [1:0] POWER_STATE_O // state
);
  logic [7:0] cfg_q;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  // own copy of port 1 config, so mode-dependent checks need no internals
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    if (!RESET_N_I) cfg_q <= RESET_CONFIG;
    else if (REG_WR_I && REG_ADDR_I == ADDR_PORT_CONFIG_A) cfg_q <= REG_WDATA_I;
  wire en1 = PORT1_SWITCH_REQUEST_I | cfg_q[BIT_SHADOW_EN];
  wire cc1 = cfg_q[BIT_CC_MODE];
  wire sw1 = PORT1_SWITCH_ON_O;
  wire sw2 = PORT2_SWITCH_ON_O;
  chk_off_reset: assert property (disable iff (1'b0) !RESET_N_I |->
    !sw1 && !sw2 && POWER_STATE_O == 2'h0) else $error("outputs live in reset");
  chk_fault_opens: assert property (PORT1_FAULT_OUT_N_OE_O |-> !sw1)
    else $error("switch closed in fault");
  chk_error_first: assert property ((PORT1_FAULT_OUT_N_OE_O || PORT2_FAULT_OUT_N_OE_O) |->
    POWER_STATE_O == 2'h2) else $error("fault without error state");
  chk_sleep_open: assert property (POWER_STATE_O == 2'h0 |-> !sw1 && !sw2)
    else $error("switch closed in sleep");
  chk_active_state: assert property ((sw1 || sw2) && !PORT1_FAULT_OUT_N_OE_O &&
    !PORT2_FAULT_OUT_N_OE_O |-> POWER_STATE_O == 2'h1) else $error("not active");
  chk_trip_opens: assert property (sw1 && !cc1 && PORT1_AT_LIMIT_I |-> ##[1:2] !sw1)
    else $error("trip did not open");
  chk_cc_holds: assert property ((sw1 && cc1 && en1 && !PORT1_VBUS_LOW_I &&
    !PORT1_OTHER_FAULT_I) [*2] |=> sw1) else $error("limited switch opened");
  chk_cc_undervolt: assert property (sw1 && cc1 && PORT1_VBUS_LOW_I |-> ##[1:2] !sw1)
    else $error("sagging port kept on");
  chk_port_isolate: assert property ($rose(PORT1_FAULT_OUT_N_OE_O) && sw2 &&
    PORT2_SWITCH_REQUEST_I && !PORT2_AT_LIMIT_I && !PORT2_VBUS_LOW_I |=> sw2)
    else $error("healthy port dropped");
  chk_cfg_readback: assert property (REG_ADDR_I == ADDR_PORT_CONFIG_A && !REG_WR_I |=>
    REG_RDATA_O == cfg_q) else $error("config readback wrong");
  cov_trip: cover property ($rose(PORT1_FAULT_OUT_N_OE_O));
  cov_recover: cover property ($fell(PORT1_FAULT_OUT_N_OE_O) ##[1:4] sw1);
  cov_sleep: cover property ($fell(POWER_STATE_O == 2'h1) && POWER_STATE_O == 2'h0);
endmodule
bind dppsc_top dppsc_top_props u_props (.*);

// file: dppsc_host.sv
// host controller model: enable pins out, open-drain alerts in
`timescale 1ns/1ps
module dppsc_host (
  input wire logic clk_i, // clock
  input wire logic [1:0] want_i, // wanted port enables
  input wire logic [1:0] alert_oe_i, // device pulls alert low
  output logic [1:0] req_o, // enable pins
  output wire logic [1:0] alert_n_o // alert wires
);
  initial req_o = 2'h0;
  // stand-alone use: pins launched just after the edge
  always @(posedge clk_i) req_o <= want_i;
  // pull-up brings the wire high whenever the device lets go
  assign alert_n_o = ~alert_oe_i;
endmodule

// file: dppsc_top_bench.sv
// self-checking bench of the dual-port power-state controller
`timescale 1ns/1ps
module dppsc_top_bench;
  import dppsc_pkg::*;
  logic clk = 0, rst_n = 1, wr = 0;
  logic [1:0] want = 0, lim = 0, vlow = 0, oth = 0;
  logic [7:0] addr = 0, wd = 0, p;
  wire [7:0] rdata;
  wire [1:0] sw, oe, st, req, aln, dn;
  int miscompares = 0, num_checks = 0;
  dppsc_top dut (.CLK_SYS_I(clk), .RESET_N_I(rst_n),
    .PORT1_SWITCH_REQUEST_I(req[0]), .PORT2_SWITCH_REQUEST_I(req[1]),
    .PORT1_AT_LIMIT_I(lim[0]), .PORT2_AT_LIMIT_I(lim[1]),
    .PORT1_VBUS_LOW_I(vlow[0]), .PORT2_VBUS_LOW_I(vlow[1]),
    .PORT1_OTHER_FAULT_I(oth[0]), .PORT2_OTHER_FAULT_I(oth[1]),
    .REG_WR_I(wr), .REG_ADDR_I(addr), .REG_WDATA_I(wd), .REG_RDATA_O(rdata),
    .PORT1_SWITCH_ON_O(sw[0]), .PORT2_SWITCH_ON_O(sw[1]),
    .PORT1_FAULT_OUT_N_O(dn[0]), .PORT2_FAULT_OUT_N_O(dn[1]),
    .PORT1_FAULT_OUT_N_OE_O(oe[0]), .PORT2_FAULT_OUT_N_OE_O(oe[1]),
    .POWER_STATE_O(st));
  dppsc_host host (.clk_i(clk), .want_i(want), .alert_oe_i(oe), .req_o(req), .alert_n_o(aln));
  initial forever #5 clk = ~clk;
  // hang guard, far beyond the recovery wait
  initial begin
    #200000;
    miscompares++;
    close_out();
  end
  // expected {state, alerts, switches}; a fault outranks any enable
  function automatic logic [7:0] exp_out(input logic [1:0] s, input logic [1:0] f);
    return {4'h0, (f != 0) ? 2'h2 : (s != 0) ? 2'h1 : 2'h0} << 4 | {f, s};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic look(input logic [7:0] e);
    #1 cmp({2'h0, st, ~aln, sw}, e);
    cmp({6'h00, dn}, 8'h00);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    tick(2);
    #1 cmp(rdata, e);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    // reset falls at time zero so no flop is unknown at the first edge
    rst_n <= 1'b0;
    void'($urandom(32'h264eb7b7));
    tick(12);
    rst_n <= 1'b1;
    rreg(ADDR_PORT_CONFIG_A, RESET_CONFIG);
    rreg(8'h20, 8'h00);
    // random pins and shadow bits, no faults; ends with sleep forced
    for (int i = 0; i < 17; i++) begin
      p = (i == 16) ? 8'h00 : 8'($urandom);
      want <= p[1:0];
      wreg(ADDR_PORT_CONFIG_A, {7'h0, p[2]});
      wreg(ADDR_PORT_CONFIG_B, {7'h0, p[3]});
      tick(4);
      look(exp_out(p[1:0] | p[3:2], 2'h0));
      rreg(ADDR_PORT_CONFIG_B, {7'h0, p[3]});
    end
    // trip on port 1 while both run, then drop both enables
    want <= 2'h3;
    tick(4);
    lim <= 2'h1;
    tick(1);
    lim <= 2'h0;
    tick(4);
    look(exp_out(2'h2, 2'h1));
    rreg(ADDR_STATUS_1, 8'h01);
    rreg(ADDR_STATUS_2, 8'h00);
    want <= 2'h0;
    tick(4);
    look(exp_out(2'h0, 2'h1));
    // supply loss mid-run clears everything
    rst_n <= 1'b0;
    tick(2);
    look(8'h00);
    rst_n <= 1'b1;
    rreg(ADDR_STATUS_1, 8'h00);
    // constant current with recovery: limit holds, sag opens, period restores
    wreg(ADDR_PORT_CONFIG_A, 8'h06);
    want <= 2'h1;
    tick(4);
    lim <= 2'h1;
    tick(6);
    look(exp_out(2'h1, 2'h0));
    vlow <= 2'h1;
    tick(1);
    vlow <= 2'h0;
    lim <= 2'h0;
    tick(4);
    look(exp_out(2'h0, 2'h1));
    tick(T_CYCLE_CNT + 10);
    look(exp_out(2'h1, 2'h0));
    // port 2 enable and trip land on one edge: the fault must win
    want <= 2'h3;
    tick(1);
    lim <= 2'h2;
    tick(1);
    lim <= 2'h0;
    tick(4);
    look(exp_out(2'h1, 2'h2));
    rreg(ADDR_STATUS_2, 8'h01);
    close_out();
  end
endmodule
